// ---- verilog/tcc_defs.vh ----
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// Printed register indices; byte address is four times the index
`define TCC_IDX_CTL1 12'h016
`define TCC_IDX_CTL2 12'h017
`define TCC_IDX_CTL3 12'h016
// Third control register sits in a separate bank window
`define TCC_BANK_CTL3 12'h100
`define TCC_ADDR_CTL1 (`TCC_IDX_CTL1 * 12'h004)
`define TCC_ADDR_CTL2 (`TCC_IDX_CTL2 * 12'h004)
`define TCC_ADDR_CTL3 (`TCC_BANK_CTL3 + `TCC_IDX_CTL3 * 12'h004)

// Data and status registers
`define TCC_ADDR_T12 12'h200
`define TCC_ADDR_PER12 12'h204
`define TCC_ADDR_T3 12'h208
`define TCC_ADDR_FLAGS 12'h240
// Capture block: 0x220..0x23F, channel in addr[4:3], high byte at addr[2]
`define TCC_CA_BLOCK 7'h11

// First control register fields
`define TCC_C1_FIRST_CS 0
`define TCC_C1_SECOND_CS 1
`define TCC_C1_CAPT_CS 2
`define TCC_C1_CHAIN 3
// Second control register fields
`define TCC_C2_FIRST_RUN 0
`define TCC_C2_SECOND_RUN 1
`define TCC_C2_CAPT_RUN 2
`define TCC_C2_PAIR_CAPT 3
`define TCC_C2_PWM1 4
`define TCC_C2_PWM2 5
`define TCC_C2_OVF1 6
`define TCC_C2_OVF2 7
// Third control register fields
`define TCC_C3_PWM3 0
`define TCC_C3_OVF3 5
`define TCC_C3_OVF4 6

// Flag register fields, write one to clear
`define TCC_FL_FIRST 0
`define TCC_FL_SECOND 1
`define TCC_FL_CAPT 2

// Reset values
`define TCC_RST_CTL1 8'h00
`define TCC_RST_CTL2 6'h00
`define TCC_RST_CTL3 5'h00

// Edge modes
`define TCC_MODE_FALL 2'b00
`define TCC_MODE_RISE 2'b01
`define TCC_MODE_RISE4 2'b10
`define TCC_MODE_RISE16 2'b11

// Instruction clock is pclk divided by four; terminal count of the divider
`define TCC_INSTR_LAST 2'd3

`endif

// ---- verilog/tcc_top.v ----
// Function
// - Two independent 8-bit up timers, each with period register and overflow flag.
// - Each 8-bit timer counts instruction clock or shared pin falling edges.
// - Software can join the two 8-bit timers into one 16-bit timer.
// - Capture timer pair acts as its period or as capture channel one.
// - First control bit 2 picks capture timer pin falling edges or internal clock.
// - First control bits 1 and 0 pick clock of second and first timer.
// - First control bit 3 chains timers, second timer as upper byte.
// - Edge modes: falling, rising, every fourth rising, every sixteenth rising.
// - Edge mode fields in first control 7-6,5-4 and third control 4-3,2-1.
// - Overrun bit sets when a capture arrives before previous value was read.
// - After overrun the oldest unread value stays until both bytes are read.
// - PWM enable forces pin to output regardless of direction bit.
// - Second control bit 3 makes the pair a capture; timer then runs free.
// - Second control bit 2 starts and stops the capture timer.
// - Second control bit 1 gates second timer; needed for chained upper byte.
// - Second control bit 0 runs the chained timer, or only the first timer.
// - Capture timer is the time-base sampled by all four capture channels.
// - PWM1 uses first timer; PWM2 and PWM3 choose first or second timer.
// - Top bit of the third control register always reads zero.
// - 8-bit timer counts to period, returns to zero, sets its flag then.
// - Chained timer counts to 16-bit period, clears next count, sets first flag.
// - Capture timer rollover to zero sets its flag.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "tcc_defs.vh"

module tcc_top #(
    parameter NCAP = 4
)
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire shared_count_input,
    input wire capture_timer_count_input,
    input wire [NCAP-1:0] capture_in,
    input wire [2:0] port_direction_bits,
    input wire pwm_two_timer_sel,
    input wire pwm_three_timer_sel,
    output wire [2:0] pwm_pin_output_en,
    output wire [2:0] pwm_period_wrap,
    output wire [7:0] first_timer_count,
    output wire [7:0] second_timer_count,
    output wire first_timer_flag,
    output wire second_timer_flag,
    output wire capture_timer_flag
);

    reg [31:0] prdata_r;
    reg pready_r;
    reg pslverr_r;
    reg [7:0] ctl1_r;
    reg [5:0] ctl2_r;
    reg [4:0] ctl3_r;
    reg [7:0] t1_r;
    reg [7:0] t2_r;
    reg [7:0] pr1_r;
    reg [7:0] pr2_r;
    reg [15:0] t3_r;
    reg [1:0] div_r;
    reg shared_prev_r;
    reg capt_pin_prev_r;
    reg fl1_r;
    reg fl2_r;
    reg fl3_r;
    reg [2:0] pwm_oe_r;
    reg [2:0] pwm_wrap_r;
    reg [31:0] rd_mux;
    reg hit;

    wire [15:0] cap_val [0:NCAP-1];
    wire [NCAP-1:0] cap_ovf;

    // Access edge: the only edge at which writes and read side effects act
    wire acc_go = psel & penable & pready_r;
    wire wr_go = acc_go & pwrite & ~pslverr_r;
    wire rd_go = acc_go & ~pwrite & ~pslverr_r;
    wire ca_sel = (paddr[11:5] == `TCC_CA_BLOCK);

    wire chain = ctl1_r[`TCC_C1_CHAIN];
    wire pair_capt = ctl2_r[`TCC_C2_PAIR_CAPT];
    wire tick = (div_r == `TCC_INSTR_LAST);
    wire shared_fall = shared_prev_r & ~shared_count_input;
    wire capt_pin_fall = capt_pin_prev_r & ~capture_timer_count_input;

    // Clock source per timer
    wire src1 = ctl1_r[`TCC_C1_FIRST_CS] ? shared_fall : tick;
    wire src2 = ctl1_r[`TCC_C1_SECOND_CS] ? shared_fall : tick;
    wire src3 = ctl1_r[`TCC_C1_CAPT_CS] ? capt_pin_fall : tick;
    wire inc1 = ctl2_r[`TCC_C2_FIRST_RUN] & src1;
    wire inc2 = ctl2_r[`TCC_C2_SECOND_RUN] & src2;
    wire inc3 = ctl2_r[`TCC_C2_CAPT_RUN] & src3;

    wire [15:0] t12 = {t2_r, t1_r};
    wire [15:0] pr12 = {pr2_r, pr1_r};
    wire match16 = (t12 == pr12);
    wire wrap1 = chain ? (inc1 & match16) : (inc1 & (t1_r == pr1_r));
    wire wrap2 = ~chain & inc2 & (t2_r == pr2_r);
    // Free run in capture mode, else pair is the period
    wire wrap3 = inc3 & (pair_capt ? (t3_r == 16'hFFFF) : (t3_r == cap_val[0]));

    wire wr_t12 = wr_go & (paddr == `TCC_ADDR_T12);
    wire wr_t3 = wr_go & (paddr == `TCC_ADDR_T3);
    wire wr_fl = wr_go & (paddr == `TCC_ADDR_FLAGS);

    // Per-channel edge modes gathered from the two control registers
    wire [7:0] edge_modes = {ctl3_r[4:3], ctl3_r[2:1], ctl1_r[7:6], ctl1_r[5:4]};

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pwm_pin_output_en = pwm_oe_r;
    assign pwm_period_wrap = pwm_wrap_r;
    assign first_timer_count = t1_r;
    assign second_timer_count = t2_r;
    assign first_timer_flag = fl1_r;
    assign second_timer_flag = fl2_r;
    assign capture_timer_flag = fl3_r;

    // Read mux, sampled in the setup cycle
    always @*
    begin
        rd_mux = 32'h0000_0000;
        hit = 1'b1;
        if (ca_sel)
        begin
            if (paddr[2])
                rd_mux = {24'h00_0000, cap_val[paddr[4:3]][15:8]};
            else
                rd_mux = {24'h00_0000, cap_val[paddr[4:3]][7:0]};
        end
        else
        begin
            case (paddr)
                `TCC_ADDR_CTL1: rd_mux = {24'h00_0000, ctl1_r};
                `TCC_ADDR_CTL2: rd_mux = {24'h00_0000, cap_ovf[1], cap_ovf[0], ctl2_r};
                `TCC_ADDR_CTL3: rd_mux = {24'h00_0000, 1'b0, cap_ovf[3], cap_ovf[2], ctl3_r};
                `TCC_ADDR_T12: rd_mux = {16'h0000, t12};
                `TCC_ADDR_PER12: rd_mux = {16'h0000, pr12};
                `TCC_ADDR_T3: rd_mux = {16'h0000, t3_r};
                `TCC_ADDR_FLAGS: rd_mux = {29'h0000_0000, fl3_r, fl2_r, fl1_r};
                default: hit = 1'b0;
            endcase
        end
    end

    // APB slave: ready is raised for exactly the first access cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= psel & ~penable;
            if (psel & ~penable)
            begin
                prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_r <= ~hit;
            end
            else if (acc_go)
            begin
                prdata_r <= 32'h0000_0000;
                pslverr_r <= 1'b0;
            end
        end
    end

    // Control registers; overrun bits are read-only
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl1_r <= `TCC_RST_CTL1;
            ctl2_r <= `TCC_RST_CTL2;
            ctl3_r <= `TCC_RST_CTL3;
            pr1_r <= 8'h00;
            pr2_r <= 8'h00;
        end
        else if (wr_go)
        begin
            if (paddr == `TCC_ADDR_CTL1)
                ctl1_r <= pwdata[7:0];
            if (paddr == `TCC_ADDR_CTL2)
                ctl2_r <= pwdata[5:0];
            if (paddr == `TCC_ADDR_CTL3)
                ctl3_r <= pwdata[4:0];
            if (paddr == `TCC_ADDR_PER12)
            begin
                pr1_r <= pwdata[7:0];
                pr2_r <= pwdata[15:8];
            end
        end
    end

    // Edge detectors and instruction-clock divider
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_r <= 2'd0;
            shared_prev_r <= 1'b1;
            capt_pin_prev_r <= 1'b1;
        end
        else
        begin
            div_r <= div_r + 2'd1;
            shared_prev_r <= shared_count_input;
            capt_pin_prev_r <= capture_timer_count_input;
        end
    end

    // First and second timers; a software write beats a count
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            t1_r <= 8'h00;
            t2_r <= 8'h00;
        end
        else if (wr_t12)
        begin
            t1_r <= pwdata[7:0];
            t2_r <= pwdata[15:8];
        end
        else if (chain)
        begin
            // Upper byte increments only while its own run bit is set; a wrap clears both bytes
            if (wrap1)
            begin
                t1_r <= 8'h00;
                t2_r <= 8'h00;
            end
            else if (inc1)
            begin
                t1_r <= t1_r + 8'h01;
                if (ctl2_r[`TCC_C2_SECOND_RUN] && t1_r == 8'hFF)
                    t2_r <= t2_r + 8'h01;
            end
        end
        else
        begin
            if (wrap1)
                t1_r <= 8'h00;
            else if (inc1)
                t1_r <= t1_r + 8'h01;
            if (wrap2)
                t2_r <= 8'h00;
            else if (inc2)
                t2_r <= t2_r + 8'h01;
        end
    end

    // Capture timer
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            t3_r <= 16'h0000;
        else if (wr_t3)
            t3_r <= pwdata[15:0];
        else if (wrap3)
            t3_r <= 16'h0000;
        else if (inc3)
            t3_r <= t3_r + 16'h0001;
    end

    // Timer flags: hardware set wins over a write-one clear
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fl1_r <= 1'b0;
            fl2_r <= 1'b0;
            fl3_r <= 1'b0;
        end
        else
        begin
            fl1_r <= wrap1 | (fl1_r & ~(wr_fl & pwdata[`TCC_FL_FIRST]));
            fl2_r <= wrap2 | (fl2_r & ~(wr_fl & pwdata[`TCC_FL_SECOND]));
            fl3_r <= wrap3 | (fl3_r & ~(wr_fl & pwdata[`TCC_FL_CAPT]));
        end
    end

    // Pin direction override and PWM time-base wrap strobes
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwm_oe_r <= 3'b000;
            pwm_wrap_r <= 3'b000;
        end
        else
        begin
            pwm_oe_r[0] <= ctl2_r[`TCC_C2_PWM1] | ~port_direction_bits[0];
            pwm_oe_r[1] <= ctl2_r[`TCC_C2_PWM2] | ~port_direction_bits[1];
            pwm_oe_r[2] <= ctl3_r[`TCC_C3_PWM3] | ~port_direction_bits[2];
            pwm_wrap_r[0] <= wrap1;
            pwm_wrap_r[1] <= pwm_two_timer_sel ? wrap2 : wrap1;
            pwm_wrap_r[2] <= pwm_three_timer_sel ? wrap2 : wrap1;
        end
    end

    // Capture channels; channel 0 shares its register with the period
    genvar gi;
    generate
        for (gi = 0; gi < NCAP; gi = gi + 1)
        begin : g_cap
            localparam [1:0] CH = gi;
            reg [15:0] val_r;
            reg prev_r;
            reg [3:0] pre_r;
            reg unread_r;
            reg lo_seen_r;
            reg hi_seen_r;
            reg ovf_r;
            wire [1:0] md = edge_modes[2*gi+1:2*gi];
            wire rise = capture_in[gi] & ~prev_r;
            wire fall = ~capture_in[gi] & prev_r;
            wire here = ca_sel & (paddr[4:3] == CH);
            wire rd_lo = rd_go & here & ~paddr[2];
            wire rd_hi = rd_go & here & paddr[2];
            wire active = (gi != 0) | pair_capt;
            reg evt_raw;
            wire evt = evt_raw & active;
            // Read complete once both bytes seen, either order
            wire done = unread_r & (lo_seen_r | rd_lo) & (hi_seen_r | rd_hi);
            // A capture that meets the completing read still loads
            wire load = evt & (~unread_r | done);
            wire wr_pair = wr_go & here & (gi == 0) & ~pair_capt;

            always @*
            begin
                case (md)
                    `TCC_MODE_FALL: evt_raw = fall;
                    `TCC_MODE_RISE: evt_raw = rise;
                    `TCC_MODE_RISE4: evt_raw = rise & (pre_r[1:0] == 2'b11);
                    `TCC_MODE_RISE16: evt_raw = rise & (pre_r == 4'hF);
                    default: evt_raw = 1'b0;
                endcase
            end

            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    val_r <= 16'h0000;
                    prev_r <= 1'b0;
                    pre_r <= 4'h0;
                    unread_r <= 1'b0;
                    lo_seen_r <= 1'b0;
                    hi_seen_r <= 1'b0;
                    ovf_r <= 1'b0;
                end
                else
                begin
                    prev_r <= capture_in[gi];
                    // Prescaler not cleared on mode change; first divided edge may come early
                    if (rise)
                        pre_r <= pre_r + 4'h1;
                    if (load)
                        val_r <= t3_r;
                    else if (wr_pair && paddr[2])
                        val_r[15:8] <= pwdata[7:0];
                    else if (wr_pair)
                        val_r[7:0] <= pwdata[7:0];
                    unread_r <= load | (unread_r & ~done);
                    lo_seen_r <= (unread_r & ~done) & (lo_seen_r | rd_lo);
                    hi_seen_r <= (unread_r & ~done) & (hi_seen_r | rd_hi);
                    ovf_r <= (evt & unread_r & ~done) | (ovf_r & ~done);
                end
            end

            assign cap_val[gi] = val_r;
            assign cap_ovf[gi] = ovf_r;
        end
    endgenerate

endmodule // tcc_top

// ---- dv/tcc_top_assertions.sv ----
`timescale 1ns/1ps
module tcc_top_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [2:0] port_direction_bits,
    input wire [2:0] pwm_pin_output_en,
    input wire [7:0] first_timer_count,
    input wire [7:0] second_timer_count,
    input wire first_timer_flag,
    input wire second_timer_flag,
    input wire capture_timer_flag
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_apb_ready: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_pin_drive: assert property (1 |=> (pwm_pin_output_en | $past(port_direction_bits)) == 3'h7)
        else $error("output pin not driven");
    a_first_wrap_zero: assert property ($rose(first_timer_flag) |-> first_timer_count == 8'h00)
        else $error("first flag without wrap");
    a_second_wrap_zero: assert property ($rose(second_timer_flag) |-> second_timer_count == 8'h00)
        else $error("second flag without wrap");
    // Writes excluded: a loaded value is not a count step
    a_count_step: assert property ($changed(first_timer_count) && !$past(psel)
        && first_timer_count != 8'h00 |-> first_timer_count == $past(first_timer_count) + 8'h01)
        else $error("count step not one");
    a_tick_gap: assert property ($changed(first_timer_count) && !$past(psel) ##1 !$past(psel)
        |-> $stable(first_timer_count))
        else $error("count ticks too close");
    a_flag_sticky: assert property (first_timer_flag && !psel |=> first_timer_flag)
        else $error("first flag dropped");
    a_capt_sticky: assert property (capture_timer_flag && !psel |=> capture_timer_flag)
        else $error("capture timer flag dropped");

    c_first_wrap: cover property ($rose(first_timer_flag));
    c_capt_wrap: cover property ($rose(capture_timer_flag));
    c_bad_addr: cover property (pslverr);
endmodule // tcc_top_checker

bind tcc_top tcc_top_checker u_chk (.pclk, .presetn, .psel, .penable, .prdata, .pready,
    .pslverr, .port_direction_bits, .pwm_pin_output_en, .first_timer_count,
    .second_timer_count, .first_timer_flag, .second_timer_flag, .capture_timer_flag);

// ---- dv/tcc_top_tb_top.sv ----
`timescale 1ns/1ps
`include "tcc_defs.vh"
module tcc_top_tb_top;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rv, d;
    logic shared_count_input = 0, capture_timer_count_input = 0, se;
    logic [3:0] capture_in = 4'h0;
    logic [2:0] port_direction_bits = 3'h7;
    logic pwm_two_timer_sel = 1, pwm_three_timer_sel = 0;
    wire [31:0] prdata;
    wire pready, pslverr, first_timer_flag, second_timer_flag, capture_timer_flag;
    wire [2:0] pwm_pin_output_en, pwm_period_wrap;
    wire [7:0] first_timer_count, second_timer_count;
    wire [2:0] fl = {capture_timer_flag, second_timer_flag, first_timer_flag};
    int mismatches = 0, compares = 0, cyc = 0, ph = 0;
    int n, p, q, c, v, v0, t0, t1, m, k;
    int tbl[4] = '{16, 16, 4, 1};
    logic [11:0] ra[3] = '{`TCC_ADDR_CTL1, `TCC_ADDR_CTL2, `TCC_ADDR_CTL3};

    tcc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .shared_count_input, .capture_timer_count_input, .capture_in,
        .port_direction_bits, .pwm_two_timer_sel, .pwm_three_timer_sel, .pwm_pin_output_en,
        .pwm_period_wrap, .first_timer_count, .second_timer_count, .first_timer_flag,
        .second_timer_flag, .capture_timer_flag);

    initial
    begin
        forever #5 pclk = ~pclk;
    end

    // Both count pins fall once every 6 cycles
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        ph <= (ph == 5) ? 0 : ph + 1;
        shared_count_input <= ph < 3;
        capture_timer_count_input <= ph < 3;
    end

    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task close_out;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task xf(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int i;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        i = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && i < 20)
        begin
            i++;
            @(posedge pclk);
        end
        if (i == 20)
            mismatches++;
        rv = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task rdcap(input int ch);
        xf(0, 12'(12'h220 + 8 * ch), 0);
        v = rv[7:0];
        xf(0, 12'(12'h224 + 8 * ch), 0);
        v = {rv[7:0], v[7:0]};
    endtask

    task pulse(input int ch);
        capture_in[ch] <= 1;
        repeat (2) @(posedge pclk);
        capture_in[ch] <= 0;
        repeat (3) @(posedge pclk);
    endtask

    task wt(input int b);
        int i;
        i = 0;
        @(posedge pclk);
        #1;
        while (fl[b] !== 1'b1 && i < 9000)
        begin
            @(posedge pclk);
            #1;
            i++;
        end
        if (i == 9000)
            mismatches++;
    endtask

    // Gap between two wraps; the first wrap may be partial
    task per(input int b);
        xf(1, `TCC_ADDR_FLAGS, 1 << b);
        wt(b);
        t0 = cyc;
        xf(1, `TCC_ADDR_FLAGS, 1 << b);
        wt(b);
        n = cyc - t0;
    endtask

    initial
    begin
        k = $urandom(87);
        repeat (3) @(posedge pclk);
        presetn <= 1;
        foreach (ra[i])
        begin
            xf(0, ra[i], 0);
            chk(rv, 32'h0);
        end
        xf(0, 12'h300, 0);
        chk(se, 1);
        chk(rv, 32'h0);
        d = $urandom;
        xf(1, `TCC_ADDR_CTL1, d[7:0]);
        xf(0, `TCC_ADDR_CTL1, 0);
        chk(rv, d[7:0]);
        xf(1, `TCC_ADDR_CTL3, 32'hFF);
        xf(0, `TCC_ADDR_CTL3, 0);
        chk(rv, 32'h1F);
        xf(1, `TCC_ADDR_CTL2, 32'hC0);
        xf(0, `TCC_ADDR_CTL2, 0);
        chk(rv, 32'h0);
        repeat (4)
        begin
            d = $urandom;
            port_direction_bits <= d[2:0];
            xf(1, `TCC_ADDR_CTL2, {d[4:3], 4'h0});
            xf(1, `TCC_ADDR_CTL3, d[5]);
            repeat (2) @(posedge pclk);
            chk(pwm_pin_output_en, {d[5:3] | ~d[2:0]});
        end
        p = $urandom % 8 + 2;
        q = $urandom % 8 + 2;
        xf(1, `TCC_ADDR_PER12, {q[7:0], p[7:0]});
        xf(1, `TCC_ADDR_CTL1, 0);
        xf(1, `TCC_ADDR_CTL2, 1);
        per(0);
        chk(n, (p + 1) * 4);
        // Wrap strobe rises with the flag and stands one cycle
        chk(pwm_period_wrap, 3'h5);
        xf(1, `TCC_ADDR_CTL1, 2);
        xf(1, `TCC_ADDR_CTL2, 2);
        #1 c = first_timer_count;
        per(1);
        chk(n, (q + 1) * 6);
        chk(pwm_period_wrap, 3'h2);
        chk(first_timer_count, c);
        xf(1, `TCC_ADDR_FLAGS, 7);
        xf(1, `TCC_ADDR_T12, 0);
        xf(1, `TCC_ADDR_PER12, {8'h01, p[7:0]});
        xf(1, `TCC_ADDR_CTL1, 8);
        xf(1, `TCC_ADDR_CTL2, 3);
        per(0);
        chk(n, (p + 257) * 4);
        chk(second_timer_flag, 0);
        xf(1, `TCC_ADDR_CTL2, 1);
        xf(1, `TCC_ADDR_T12, 0);
        repeat (1200) @(posedge pclk);
        chk(second_timer_count, 0);
        xf(1, `TCC_ADDR_CTL1, 0);
        xf(1, 12'h220, p);
        xf(1, 12'h224, 0);
        xf(1, `TCC_ADDR_CTL2, 4);
        per(2);
        chk(n, (p + 1) * 4);
        xf(1, `TCC_ADDR_CTL1, 4);
        per(2);
        chk(n, (p + 1) * 6);
        xf(1, `TCC_ADDR_CTL2, 0);
        xf(0, `TCC_ADDR_T3, 0);
        c = rv;
        repeat (20) @(posedge pclk);
        xf(0, `TCC_ADDR_T3, 0);
        chk(rv, c);
        xf(1, `TCC_ADDR_CTL2, 12);
        for (k = 0; k < 16; k++)
        begin
            m = k % 4;
            if (k < 8)
                xf(1, `TCC_ADDR_CTL1, m << (k < 4 ? 4 : 6));
            else
                xf(1, `TCC_ADDR_CTL3, m << (k < 12 ? 1 : 3));
            rdcap(k / 4);
            v0 = v;
            c = 0;
            repeat (16)
            begin
                pulse(k / 4);
                rdcap(k / 4);
                c += (v != v0);
                v0 = v;
            end
            chk(c, tbl[m]);
        end
        xf(1, `TCC_ADDR_CTL1, 8'h40);
        rdcap(1);
        xf(0, `TCC_ADDR_T3, 0);
        t0 = rv[15:0];
        pulse(1);
        xf(0, `TCC_ADDR_T3, 0);
        t1 = rv[15:0];
        repeat (40) @(posedge pclk);
        pulse(1);
        xf(0, `TCC_ADDR_CTL2, 0);
        chk(rv[7], 1);
        rdcap(1);
        chk(v >= t0 && v <= t1, 1);
        xf(0, `TCC_ADDR_CTL2, 0);
        chk(rv[7], 0);
        pulse(1);
        rdcap(1);
        chk(v > t1, 1);
        close_out;
    end

    initial
    begin
        repeat (60000) @(posedge pclk);
        mismatches++;
        close_out;
    end
endmodule // tcc_top_tb_top
